/* File: shared/serial_transmit_control_regs.vh */
// Register offsets, field positions, reset values and timing constants
`ifndef SERIAL_TRANSMIT_CONTROL_REGS_VH
`define SERIAL_TRANSMIT_CONTROL_REGS_VH

// Register selects within the device (word index on the register port)
`define TCS_SEL            1'b0
`define TDB_SEL            1'b1

// Transmit control/status fields
`define BAUD_SEL_HI        15
`define BAUD_SEL_LO        12
`define BAUD_PROG_EN_BIT   11
`define TX_READY_BIT       7
`define TX_INT_EN_BIT      6
`define LOOPBACK_BIT       2
`define BREAK_BIT          0

// Transmit data field
`define TX_DATA_HI         7
`define TX_DATA_LO         0

// Reset values
`define BAUD_SEL_RESET     4'h0
`define CTRL_BIT_RESET     1'b0

// Clock rate and baud timing
`define CLOCK_HZ           25000000
`define OVERSAMPLE         16
`define CHAR_BITS          4'ha
`define BIT_TICKS          5'h10

`endif

/* File: verilog/baud_rate_table.v */
// Baud rate divisor lookup, registered output
`timescale 1ns/1ps
module baud_rate_table #(
    parameter CLOCK_HZ = 25000000
) (
    // Clock
    input  wire        clock,
    // Lookup
    input  wire [3:0]  select,
    output reg  [15:0] divisor
);

    // Rates times ten: 50 .. 9600 and 19200 in the top entry
    function [31:0] rate_x10;
        input [3:0] s;
        begin
            case (s)
                4'h0: rate_x10 = 32'd500;
                4'h1: rate_x10 = 32'd750;
                4'h2: rate_x10 = 32'd1100;
                4'h3: rate_x10 = 32'd1345;
                4'h4: rate_x10 = 32'd1500;
                4'h5: rate_x10 = 32'd3000;
                4'h6: rate_x10 = 32'd6000;
                4'h7: rate_x10 = 32'd12000;
                4'h8: rate_x10 = 32'd18000;
                4'h9: rate_x10 = 32'd20000;
                4'ha: rate_x10 = 32'd24000;
                4'hb: rate_x10 = 32'd36000;
                4'hc: rate_x10 = 32'd48000;
                4'hd: rate_x10 = 32'd72000;
                4'he: rate_x10 = 32'd96000;
                default: rate_x10 = 32'd192000;
            endcase
        end
    endfunction

    // Full-width quotient; every table entry fits in sixteen bits
    wire [31:0] full_divisor = ((CLOCK_HZ / 16) * 10) / rate_x10(select);

    // Sixteen-times oversample divisor, registered
    always @(posedge clock) begin
        divisor <= full_divisor[15:0];
    end

endmodule // baud_rate_table

/* File: verilog/serial_transmit_control.v */
// Transmitter control/status, transmit buffer, serialiser and baud logic
// Notes on behaviour
// - Four-bit select picks rate, write-only
// - New rate only when enable bit written
// - Ready flag set when buffer empties
// - Ready and enable start interrupt request
// - Interrupt enable read/write, cleared by initialize
// - Loopback routes transmit output to receiver
// - Loopback common speed: receiver uses transmit clock
// - Break drives continuous space on output
// - Data buffer write-only, reads return zero
// - Initialize performs every clearing action
// - Select sets receive only when split speed
// - Receiver requests win the acknowledge chain
`timescale 1ns/1ps
`include "serial_transmit_control_regs.vh"
module serial_transmit_control #(
    parameter CLOCK_HZ    = `CLOCK_HZ,
    parameter DATA_WIDTH  = 8
) (
    // Clock and bus initialize
    input  wire        CLOCK,
    input  wire        RST,
    // Register port
    input  wire        REG_SEL,
    input  wire        REG_WRITE,
    input  wire        REG_READ,
    input  wire [1:0]  BYTE_EN,
    input  wire [15:0] WRITE_DATA,
    output reg  [15:0] READ_DATA,
    // Baud configuration straps
    input  wire        COMMON_SPEED,
    input  wire [3:0]  STRAP_RX_SEL,
    input  wire [3:0]  STRAP_TX_SEL,
    // Interrupt request and daisy chain
    input  wire        RX_INT_REQUEST,
    input  wire        ACK_IN,
    output wire        TX_INT_REQUEST,
    output wire        ACK_OUT,
    output wire        RX_VECTOR,
    output wire        TX_VECTOR,
    // Serial line
    input  wire        LINE_RX,
    output reg         LINE_TX,
    // Toward the receiver section
    output wire        RX_SERIAL_IN,
    output wire        RX_BAUD_TICK
);

    // One-hot transmitter states
    localparam [2:0] S_IDLE  = 3'b001;
    localparam [2:0] S_LOAD  = 3'b010;
    localparam [2:0] S_SHIFT = 3'b100;

    // Control state
    reg [3:0]  baud_select_field;
    reg        prog_rate_active;
    reg        transmitter_interrupt_enable;
    reg        loopback_maintenance;
    reg        break_enable;
    reg        buffer_full;
    reg [DATA_WIDTH-1:0] transmit_data_buffer;
    reg [DATA_WIDTH-1:0] shift_data;
    reg [9:0]  shift_reg;
    reg [3:0]  bit_count;
    reg [4:0]  tick_count;
    reg [2:0]  state;
    reg [2:0]  next_state;
    reg [15:0] tx_div_count;
    reg [15:0] rx_div_count;
    reg        tx_tick;
    reg        rx_tick;
    reg        line_meta;
    reg        line_sync;

    wire [3:0]  tx_sel;
    wire [3:0]  rx_sel;
    wire [15:0] tx_divisor;
    wire [15:0] rx_divisor;
    wire        transmitter_ready_flag;
    wire        tcs_write;
    wire        tdb_write;

    // Register access decode
    assign tcs_write = REG_WRITE && (REG_SEL == `TCS_SEL);
    assign tdb_write = REG_WRITE && (REG_SEL == `TDB_SEL) && BYTE_EN[0];

    // Rate selection between program and straps
    assign rx_sel = prog_rate_active ? baud_select_field : STRAP_RX_SEL;
    assign tx_sel = COMMON_SPEED ? rx_sel : STRAP_TX_SEL;

    baud_rate_table #(.CLOCK_HZ(CLOCK_HZ)) tx_table (
        .clock   (CLOCK),
        .select  (tx_sel),
        .divisor (tx_divisor)
    );

    baud_rate_table #(.CLOCK_HZ(CLOCK_HZ)) rx_table (
        .clock   (CLOCK),
        .select  (rx_sel),
        .divisor (rx_divisor)
    );

    // Control register writes and initialize
    always @(posedge CLOCK) begin
        if (RST) begin
            baud_select_field            <= `BAUD_SEL_RESET;
            prog_rate_active             <= `CTRL_BIT_RESET;
            transmitter_interrupt_enable <= `CTRL_BIT_RESET;
            loopback_maintenance         <= `CTRL_BIT_RESET;
            break_enable                 <= `CTRL_BIT_RESET;
        end else if (tcs_write) begin
            if (BYTE_EN[1] && WRITE_DATA[`BAUD_PROG_EN_BIT]) begin
                baud_select_field <= WRITE_DATA[`BAUD_SEL_HI:`BAUD_SEL_LO];
                prog_rate_active  <= 1'b1;
            end
            if (BYTE_EN[0]) begin
                transmitter_interrupt_enable <= WRITE_DATA[`TX_INT_EN_BIT];
                loopback_maintenance         <= WRITE_DATA[`LOOPBACK_BIT];
                break_enable                 <= WRITE_DATA[`BREAK_BIT];
            end
        end
    end

    // Transmit baud divider, sixteen ticks per bit
    always @(posedge CLOCK) begin
        if (RST) begin
            tx_div_count <= 16'h0000;
            tx_tick      <= 1'b0;
        end else if (tx_div_count >= tx_divisor - 16'h0001) begin
            tx_div_count <= 16'h0000;
            tx_tick      <= 1'b1;
        end else begin
            tx_div_count <= tx_div_count + 16'h0001;
            tx_tick      <= 1'b0;
        end
    end

    // Receive baud divider
    always @(posedge CLOCK) begin
        if (RST) begin
            rx_div_count <= 16'h0000;
            rx_tick      <= 1'b0;
        end else if (rx_div_count >= rx_divisor - 16'h0001) begin
            rx_div_count <= 16'h0000;
            rx_tick      <= 1'b1;
        end else begin
            rx_div_count <= rx_div_count + 16'h0001;
            rx_tick      <= 1'b0;
        end
    end

    // Loopback with common speed forces transmit clock on receiver
    assign RX_BAUD_TICK = (loopback_maintenance && COMMON_SPEED) ? tx_tick : rx_tick;

    // External line synchroniser
    always @(posedge CLOCK) begin
        if (RST) begin
            line_meta <= 1'b1;
            line_sync <= 1'b1;
        end else begin
            line_meta <= LINE_RX;
            line_sync <= line_meta;
        end
    end

    // Loopback disconnects the external line from the receiver
    assign RX_SERIAL_IN = loopback_maintenance ? shift_reg[0] : line_sync;

    // Holding buffer: write fills, serialiser load empties
    always @(posedge CLOCK) begin
        if (RST) begin
            buffer_full          <= 1'b0;
            transmit_data_buffer <= {DATA_WIDTH{1'b0}};
        end else if (tdb_write && !buffer_full) begin
            buffer_full          <= 1'b1;
            transmit_data_buffer <= WRITE_DATA[DATA_WIDTH-1:0];
        end else if (state == S_LOAD) begin
            buffer_full <= 1'b0;
        end
    end

    // Ready whenever the buffer can take a character
    assign transmitter_ready_flag = !buffer_full;

    // Transmitter next state
    always @* begin
        next_state = state;
        case (state)
            S_IDLE:  if (buffer_full) next_state = S_LOAD;
            S_LOAD:  next_state = S_SHIFT;
            S_SHIFT: if (tx_tick && tick_count == `BIT_TICKS - 5'h01
                         && bit_count == `CHAR_BITS - 4'h1) next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // Serialiser: start bit, eight data bits, stop bit
    always @(posedge CLOCK) begin
        if (RST) begin
            state      <= S_IDLE;
            shift_reg  <= 10'h3ff;
            shift_data <= {DATA_WIDTH{1'b0}};
            bit_count  <= 4'h0;
            tick_count <= 5'h00;
        end else begin
            state <= next_state;
            case (state)
                S_LOAD: begin
                    shift_data <= transmit_data_buffer;
                    shift_reg  <= {1'b1, transmit_data_buffer, 1'b0};
                    bit_count  <= 4'h0;
                    tick_count <= 5'h00;
                end
                S_SHIFT: begin
                    if (tx_tick) begin
                        if (tick_count == `BIT_TICKS - 5'h01) begin
                            tick_count <= 5'h00;
                            bit_count  <= bit_count + 4'h1;
                            shift_reg  <= {1'b1, shift_reg[9:1]};
                        end else begin
                            tick_count <= tick_count + 5'h01;
                        end
                    end
                end
                default: shift_reg <= 10'h3ff;
            endcase
        end
    end

    // Line output: break forces space
    always @(posedge CLOCK) begin
        if (RST) begin
            LINE_TX <= 1'b1;
        end else begin
            LINE_TX <= break_enable ? 1'b0 : shift_reg[0];
        end
    end

    // Interrupt request and daisy chain, receiver first
    assign TX_INT_REQUEST = transmitter_ready_flag && transmitter_interrupt_enable;
    assign RX_VECTOR      = ACK_IN && RX_INT_REQUEST;
    assign TX_VECTOR      = ACK_IN && !RX_INT_REQUEST && TX_INT_REQUEST;
    assign ACK_OUT        = ACK_IN && !RX_INT_REQUEST && !TX_INT_REQUEST;

    // Read data; write-only fields and data buffer read as zero
    always @(posedge CLOCK) begin
        if (RST) begin
            READ_DATA <= 16'h0000;
        end else if (REG_READ && REG_SEL == `TCS_SEL) begin
            READ_DATA <= 16'h0000;
            READ_DATA[`TX_READY_BIT]  <= transmitter_ready_flag;
            READ_DATA[`TX_INT_EN_BIT] <= transmitter_interrupt_enable;
            READ_DATA[`LOOPBACK_BIT]  <= loopback_maintenance;
            READ_DATA[`BREAK_BIT]     <= break_enable;
        end else if (REG_READ) begin
            READ_DATA <= 16'h0000;
        end
    end

endmodule // serial_transmit_control

/* File: verification/serial_transmit_control_asserts.sv */
// Port-level checker for the transmit control block
`timescale 1ns/1ps
module serial_transmit_control_asserts (
    // Clock and initialize
    input wire        CLOCK,
    input wire        RST,
    // Register port
    input wire        REG_SEL,
    input wire        REG_WRITE,
    input wire        REG_READ,
    input wire [1:0]  BYTE_EN,
    input wire [15:0] WRITE_DATA,
    input wire [15:0] READ_DATA,
    // Interrupt chain
    input wire        RX_INT_REQUEST,
    input wire        ACK_IN,
    input wire        TX_INT_REQUEST,
    input wire        ACK_OUT,
    input wire        TX_VECTOR,
    // Serial side
    input wire        LINE_RX,
    input wire        LINE_TX,
    input wire        RX_SERIAL_IN
);
    reg  ien;
    reg  loop;
    reg  brk;
    wire ctl_wr = REG_WRITE && !REG_SEL && BYTE_EN[0];
    wire dat_wr = REG_WRITE && REG_SEL && BYTE_EN[0];
    // Shadow of the low-lane control bits
    always @(posedge CLOCK) begin
        if (RST) begin
            {ien, loop, brk} <= 3'h0;
        end else if (ctl_wr) begin
            {ien, loop, brk} <= {WRITE_DATA[6], WRITE_DATA[2], WRITE_DATA[0]};
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence s_load; dat_wr && TX_INT_REQUEST; endsequence
    sequence s_busy; !TX_INT_REQUEST [*2]; endsequence
    a_ready_falls: assert property (s_load |=> s_busy)
        else $error("ready did not fall after data write");
    a_int_needs_en: assert property (TX_INT_REQUEST |-> ien)
        else $error("request without enable");
    a_break_space: assert property (brk && $past(brk) |-> !LINE_TX)
        else $error("break not spacing");
    a_line_reaches_rx: assert property (!loop && $past(!RST, 3) |-> RX_SERIAL_IN == $past(LINE_RX, 2))
        else $error("receiver input not from line");
    a_ctl_read_back: assert property (
        REG_READ && !REG_SEL |=> READ_DATA[15:8] == 8'h00
        && {READ_DATA[6], READ_DATA[2], READ_DATA[0]} == $past({ien, loop, brk}))
        else $error("control read mismatch");
    a_buf_read_zero: assert property (REG_READ && REG_SEL |=> READ_DATA == 16'h0000)
        else $error("buffer read not zero");
    a_init_clears: assert property (@(posedge CLOCK) disable iff (1'b0)
        RST |=> LINE_TX && !TX_INT_REQUEST && READ_DATA == 16'h0000)
        else $error("initialize did not clear");
    a_ack_rx_first: assert property (ACK_IN && RX_INT_REQUEST |-> !TX_VECTOR && !ACK_OUT)
        else $error("transmitter beat receiver");
endmodule // serial_transmit_control_asserts

bind serial_transmit_control serial_transmit_control_asserts u_serial_transmit_control_asserts (
    .CLOCK(CLOCK), .RST(RST), .REG_SEL(REG_SEL), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ),
    .BYTE_EN(BYTE_EN), .WRITE_DATA(WRITE_DATA), .READ_DATA(READ_DATA),
    .RX_INT_REQUEST(RX_INT_REQUEST), .ACK_IN(ACK_IN), .TX_INT_REQUEST(TX_INT_REQUEST),
    .ACK_OUT(ACK_OUT), .TX_VECTOR(TX_VECTOR), .LINE_RX(LINE_RX), .LINE_TX(LINE_TX),
    .RX_SERIAL_IN(RX_SERIAL_IN));

/* File: verification/serial_line_peer.sv */
// Far-end serial peripheral: drives the line, decodes frames
`timescale 1ns/1ps
module serial_line_peer (
    // Clock
    input  wire logic  clock,
    // Line
    input  wire logic  line_in,
    output logic       line_out,
    // Bench side
    input  wire logic  send_space,
    output logic [7:0] char_out,
    output logic       char_done
);
    // Mark when idle, space on command
    assign line_out = !send_space;
    // Start bit sets the bit time; first data bit must be a mark
    initial begin : rx
        int w;
        char_done = 1'b0;
        char_out = 8'h00;
        forever begin
            @(negedge line_in);
            w = 0;
            while (!line_in) begin
                @(posedge clock);
                w++;
            end
            repeat (w / 2) @(posedge clock);
            for (int i = 0; i < 8; i++) begin
                char_out[i] = line_in;
                repeat (w) @(posedge clock);
            end
            char_done = 1'b1;
            @(posedge clock);
            char_done = 1'b0;
        end
    end
endmodule // serial_line_peer

/* File: verification/serial_transmit_control_test.sv */
// Self-checking bench for the transmit control block
`timescale 1ns/1ps
`include "serial_transmit_control_regs.vh"
module serial_transmit_control_test;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        sel = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [1:0]  be = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic        rx_irq = 1'b0;
    logic        ack_in = 1'b0;
    logic        space = 1'b0;
    logic        common = 1'b0;
    logic [15:0] rdata, val;
    logic        line_rx, line_tx, tx_irq, ack_out, tx_vec, rx_ser, tick, done;
    logic [7:0]  got;
    int          n_fail = 0, cmp_count = 0, cycles = 0, n_tick = 0, p0, t;

    serial_transmit_control u_serial_transmit_control (
        .CLOCK(clock), .RST(rst), .REG_SEL(sel), .REG_WRITE(wr), .REG_READ(rd),
        .BYTE_EN(be), .WRITE_DATA(wdata), .READ_DATA(rdata), .COMMON_SPEED(common),
        .STRAP_RX_SEL(4'hf), .STRAP_TX_SEL(4'hf), .RX_INT_REQUEST(rx_irq), .ACK_IN(ack_in),
        .TX_INT_REQUEST(tx_irq), .ACK_OUT(ack_out), .RX_VECTOR(), .TX_VECTOR(tx_vec),
        .LINE_RX(line_rx), .LINE_TX(line_tx), .RX_SERIAL_IN(rx_ser), .RX_BAUD_TICK(tick));
    serial_line_peer u_serial_line_peer (.clock(clock), .line_in(line_tx),
        .line_out(line_rx), .send_space(space), .char_out(got), .char_done(done));

    initial forever #20 clock = ~clock;
    always @(posedge tick) n_tick++;

    task automatic chk(input logic [15:0] g, e, input string what);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, g, e);
        end
    endtask
    task automatic reg_wr(input logic s, input logic [1:0] b, input logic [15:0] d);
        @(negedge clock);
        {sel, be, wdata, wr} = {s, b, d, 1'b1};
        @(negedge clock);
        wr = 1'b0;
    endtask
    task automatic reg_rd(input logic s, output logic [15:0] d);
        @(negedge clock);
        {sel, rd} = {s, 1'b1};
        @(negedge clock);
        rd = 1'b0;
        @(negedge clock);
        d = rdata;
    endtask
    task automatic wait_char(input logic [7:0] e);
        for (int k = 0; k < 20000 && done !== 1'b1; k++) @(negedge clock);
        chk({7'h00, done, got}, {8'h01, e}, "char");
        @(negedge clock);
    endtask
    task stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 50000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            stop_test;
        end
    end

    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        reg_rd(`TCS_SEL, val);
        chk(val, 16'h0080, "ctl reset");
        reg_rd(`TDB_SEL, val);
        chk(val, 16'h0000, "buf read");
        reg_wr(`TCS_SEL, 2'h3, 16'hf8c5);
        reg_rd(`TCS_SEL, val);
        chk(val, 16'h00c5, "ctl read");
        chk({15'h0, tx_irq}, 16'h0001, "request");
        chk({15'h0, line_tx}, 16'h0000, "break");
        space = 1'b1;
        repeat (4) @(negedge clock);
        chk({15'h0, rx_ser}, 16'h0001, "loop isolates");
        // Daisy chain: receiver first, then transmitter
        {ack_in, rx_irq} = 2'h3;
        #1 chk({14'h0, tx_vec, ack_out}, 16'h0000, "rx wins");
        rx_irq = 1'b0;
        #1 chk({14'h0, tx_vec, ack_out}, 16'h0002, "tx vector");
        ack_in = 1'b0;
        // Initialize in mid-run
        rst = 1'b1;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        reg_rd(`TCS_SEL, val);
        chk(val, 16'h0080, "ctl init");
        chk({15'h0, rx_ser}, 16'h0000, "line to rx");
        space = 1'b0;
        // Receive rate moves only with the enable bit
        @(posedge tick);
        t = cycles;
        @(posedge tick);
        p0 = cycles - t;
        reg_wr(`TCS_SEL, 2'h2, 16'h0000);
        @(posedge tick);
        t = cycles;
        @(posedge tick);
        chk(16'(cycles - t), 16'(p0), "rate kept");
        reg_wr(`TCS_SEL, 2'h2, 16'h0800);
        t = n_tick;
        repeat (4 * p0) @(negedge clock);
        chk({15'h0, n_tick - t < 2}, 16'h0001, "rate slowed");
        // Two characters back to back, third refused while full
        reg_wr(`TCS_SEL, 2'h1, 16'h0040);
        reg_wr(`TDB_SEL, 2'h1, 16'hff55);
        chk({15'h0, tx_irq}, 16'h0000, "ready falls");
        for (int k = 0; k < 10 && tx_irq !== 1'b1; k++) @(negedge clock);
        chk({15'h0, tx_irq}, 16'h0001, "ready back");
        reg_wr(`TDB_SEL, 2'h1, 16'h00a3);
        repeat (20) @(negedge clock);
        chk({15'h0, tx_irq}, 16'h0000, "buffer full");
        reg_wr(`TDB_SEL, 2'h1, 16'h000f);
        wait_char(8'h55);
        wait_char(8'ha3);
        repeat (3000) @(negedge clock);
        chk({14'h0, tx_irq, line_tx}, 16'h0003, "idle");
        reg_wr(`TCS_SEL, 2'h1, 16'h0000);
        chk({15'h0, tx_irq}, 16'h0000, "enable cleared");
        // Loopback under common speed: receiver runs at transmit rate
        rst = 1'b1;
        repeat (3) @(negedge clock);
        {rst, common} = 2'h1;
        reg_wr(`TCS_SEL, 2'h1, 16'h0004);
        @(posedge tick);
        t = cycles;
        @(posedge tick);
        chk(16'(cycles - t), 16'(p0), "common loop rate");
        stop_test;
    end
endmodule // serial_transmit_control_test
